// File: hw/dac_cmd_pkg.sv
// Shared constants and types for the serial command decoder.
package dac_cmd_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned DIR_POS = 23;
  localparam int unsigned ZERO_POS = 22;
  localparam int unsigned DATA_BITS = 16;
  localparam logic [4:0] FRAME_COUNT = 5'h18;
  // ----------------------------------------------------------------
  // Target register and channel codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TGT_DATA = 3'h0;
  localparam logic [2:0] TGT_RANGE = 3'h1;
  localparam logic [2:0] TGT_POWER = 3'h2;
  localparam logic [2:0] TGT_CONTROL = 3'h3;
  localparam logic [2:0] TGT_LAST = 3'h3;
  localparam logic [2:0] CHAN_ALL = 3'h4;
  localparam logic [3:0] MASK_ALL = 4'hf;
  // ----------------------------------------------------------------
  // Range field and code conventions
  // ----------------------------------------------------------------
  localparam logic [2:0] RANGE_BIPOLAR_MIN = 3'h3;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam int unsigned CODE_BITS = 12;
  localparam int unsigned CODE_LSB = 4;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [23:0] FRAME_RESET = 24'h000000;
  typedef struct packed {
    logic rd;
    logic zero;
    logic [2:0] target;
    logic [2:0] chan;
    logic [15:0] data;
  } cmd_s;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SHIFT = 4'h2,
    ST_DECODE = 4'h4,
    ST_FETCH = 4'h8
  } state_e;
endpackage

// File: hw/cmd_reg_store.sv
// Register storage: four target registers per channel, registered read.
`timescale 1ns/100ps
`default_nettype none
module cmd_reg_store (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_sel_i,
  input wire logic [3:0] wr_mask_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [1:0] rd_sel_i,
  input wire logic [1:0] rd_ch_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [16];
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= dac_cmd_pkg::WORD_RESET;
      end
      rd_data_o <= dac_cmd_pkg::WORD_RESET;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (wr_en_i && wr_mask_i[c]) begin
          mem[{wr_sel_i, 2'(c)}] <= wr_data_i;
        end
      end
      if (rd_en_i) begin
        rd_data_o <= mem[{rd_sel_i, rd_ch_i}];
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/quad_dac_serial_command_decoder.sv
// Serial command decoder: frame capture, decode, storage and readback.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Frames are 24 bits, assembled in shifter.
// - Bits arrive and shift in MSB first.
// - Bit 23 is the read/write direction flag.
// - Bits 21..19 select data/range/power/control register.
// - Bits 15..0 are the payload.
// - Every register is writable and readable back.
// - Bipolar codes are twos complement.
// - Unipolar codes are straight binary.
module quad_dac_serial_command_decoder (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic serial_clk_i,
  input wire logic frame_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output dac_cmd_pkg::cmd_s cmd_o,
  output logic cmd_valid_o,
  output logic [1:0] level_ch_o,
  output logic signed [12:0] level_o,
  output logic level_valid_o
);
  // ----------------------------------------------------------------
  // Code conversion
  // ----------------------------------------------------------------
  // Maps a 12-bit code to a signed step count from zero output.
  function automatic logic signed [12:0] code_to_level(input logic [11:0] code, input logic bipolar);
    code_to_level = bipolar ? {code[11], code} : {1'b0, code};
  endfunction
  // Turns a channel field into a write mask; broadcast hits all four.
  function automatic logic [3:0] chan_mask(input logic [2:0] chan);
    chan_mask = (chan == dac_cmd_pkg::CHAN_ALL) ? dac_cmd_pkg::MASK_ALL :
                (chan[2] ? 4'h0 : 4'(4'h1 << chan[1:0]));
  endfunction
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_q;
  logic [2:0] frame_q;
  logic [1:0] serial_data_in_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sclk_q <= 3'h0;
      frame_q <= 3'h7;
      serial_data_in_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], serial_clk_i};
      frame_q <= {frame_q[1:0], frame_n_i};
      serial_data_in_q <= {serial_data_in_q[0], serial_data_in_i};
    end
  end
  wire sclk_fall = sclk_q[2] & ~sclk_q[1];
  wire sclk_rise = ~sclk_q[2] & sclk_q[1];
  wire frame_start = frame_q[2] & ~frame_q[1];
  wire frame_end = ~frame_q[2] & frame_q[1];
  wire serial_data_in_s = serial_data_in_q[1];
  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  dac_cmd_pkg::state_e state;
  dac_cmd_pkg::state_e next_state;
  logic [23:0] shreg;
  logic [4:0] bit_cnt;
  logic [23:0] sdo_shift;
  logic [2:0] range_sel [4];
  dac_cmd_pkg::cmd_s frame_cmd;
  assign frame_cmd = dac_cmd_pkg::cmd_s'(shreg);
  wire full_frame = (bit_cnt == dac_cmd_pkg::FRAME_COUNT);
  wire target_ok = (frame_cmd.target <= dac_cmd_pkg::TGT_LAST);
  wire [3:0] wr_mask = chan_mask(frame_cmd.chan);
  wire in_decode = (state == dac_cmd_pkg::ST_DECODE);
  wire wr_en = in_decode & ~frame_cmd.rd & target_ok & (wr_mask != 4'h0);
  wire rd_en = in_decode & frame_cmd.rd;
  wire [1:0] rd_ch = frame_cmd.chan[2] ? 2'h0 : frame_cmd.chan[1:0];
  wire level_hit = wr_en & (frame_cmd.target == dac_cmd_pkg::TGT_DATA);
  wire [1:0] level_ch = rd_ch;
  wire bipolar = (range_sel[level_ch] >= dac_cmd_pkg::RANGE_BIPOLAR_MIN);
  wire [11:0] dac_code = frame_cmd.data[dac_cmd_pkg::CODE_LSB +: dac_cmd_pkg::CODE_BITS];
  wire [15:0] rd_data;
  always_comb begin
    next_state = state;
    unique case (state)
      dac_cmd_pkg::ST_IDLE: begin
        if (frame_start) begin
          next_state = dac_cmd_pkg::ST_SHIFT;
        end
      end
      dac_cmd_pkg::ST_SHIFT: begin
        if (frame_end) begin
          next_state = full_frame ? dac_cmd_pkg::ST_DECODE : dac_cmd_pkg::ST_IDLE;
        end
      end
      dac_cmd_pkg::ST_DECODE: begin
        next_state = frame_cmd.rd ? dac_cmd_pkg::ST_FETCH : dac_cmd_pkg::ST_IDLE;
      end
      dac_cmd_pkg::ST_FETCH: begin
        next_state = dac_cmd_pkg::ST_IDLE;
      end
      default: begin
        next_state = dac_cmd_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= dac_cmd_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shreg <= dac_cmd_pkg::FRAME_RESET;
      bit_cnt <= 5'h0;
    end else if (frame_start) begin
      bit_cnt <= 5'h0;
    end else if (state == dac_cmd_pkg::ST_SHIFT && sclk_fall && !full_frame) begin
      shreg <= {shreg[22:0], serial_data_in_s};
      bit_cnt <= bit_cnt + 5'h1;
    end
  end
  // ----------------------------------------------------------------
  // Decode outputs and range tracking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_o <= dac_cmd_pkg::cmd_s'(dac_cmd_pkg::FRAME_RESET);
      cmd_valid_o <= 1'b0;
      level_o <= 13'sh0;
      level_ch_o <= 2'h0;
      level_valid_o <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        range_sel[i] <= dac_cmd_pkg::RANGE_RESET;
      end
    end else begin
      cmd_valid_o <= in_decode;
      if (in_decode) begin
        cmd_o <= frame_cmd;
      end
      level_valid_o <= level_hit;
      if (level_hit) begin
        level_o <= code_to_level(dac_code, bipolar);
        level_ch_o <= level_ch;
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_en && wr_mask[i] && frame_cmd.target == dac_cmd_pkg::TGT_RANGE) begin
          range_sel[i] <= frame_cmd.data[2:0];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Register storage and readback
  // ----------------------------------------------------------------
  cmd_reg_store u_store (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_en),
    .wr_sel_i(frame_cmd.target[1:0]),
    .wr_mask_i(wr_mask),
    .wr_data_i(frame_cmd.data),
    .rd_en_i(rd_en),
    .rd_sel_i(frame_cmd.target[1:0]),
    .rd_ch_i(rd_ch),
    .rd_data_o(rd_data)
  );
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sdo_shift <= dac_cmd_pkg::FRAME_RESET;
      serial_data_out_o <= 1'b0;
    end else if (state == dac_cmd_pkg::ST_FETCH) begin
      sdo_shift <= {cmd_o[23:16], rd_data};
    end else if (frame_start) begin
      serial_data_out_o <= sdo_shift[23];
      sdo_shift <= {sdo_shift[22:0], 1'b0};
    end else if (state == dac_cmd_pkg::ST_SHIFT && sclk_rise) begin
      serial_data_out_o <= sdo_shift[23];
      sdo_shift <= {sdo_shift[22:0], 1'b0};
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_frame_done;
    state == dac_cmd_pkg::ST_SHIFT && frame_end && full_frame;
  endsequence
  property p_full_frame;
    @(posedge ref_clk_i) disable iff (rst_i) s_frame_done |=> in_decode ##1 cmd_valid_o;
  endproperty
  a_full_frame: assert property (p_full_frame) else $error("Complete frame not decoded.");
  property p_msb_first;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state == dac_cmd_pkg::ST_SHIFT && sclk_fall && !full_frame && !frame_start)
      |=> shreg[0] == $past(serial_data_in_s) && shreg[23:1] == $past(shreg[22:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("Frame bit not shifted in MSB first.");
  property p_partial_drop;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state == dac_cmd_pkg::ST_SHIFT && frame_end && !full_frame) |=> state == dac_cmd_pkg::ST_IDLE ##1 !cmd_valid_o;
  endproperty
  a_partial_drop: assert property (p_partial_drop) else $error("Partial frame was acted on.");
  property p_read_path;
    @(posedge ref_clk_i) disable iff (rst_i) (in_decode && frame_cmd.rd) |-> !wr_en ##1 state == dac_cmd_pkg::ST_FETCH;
  endproperty
  a_read_path: assert property (p_read_path) else $error("Read frame did not fetch.");
  property p_write_path;
    @(posedge ref_clk_i) disable iff (rst_i) wr_en |-> !frame_cmd.rd && frame_cmd.target <= dac_cmd_pkg::TGT_LAST;
  endproperty
  a_write_path: assert property (p_write_path) else $error("Write issued for a read or bad target.");
  property p_broadcast;
    @(posedge ref_clk_i) disable iff (rst_i) (in_decode && frame_cmd.chan == dac_cmd_pkg::CHAN_ALL) |-> wr_mask == 4'hf;
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("Broadcast did not reach all channels.");
  property p_cmd_fields;
    @(posedge ref_clk_i) disable iff (rst_i) in_decode |=> cmd_o.data == $past(shreg[15:0]) && cmd_o.target == $past(shreg[21:19]);
  endproperty
  a_cmd_fields: assert property (p_cmd_fields) else $error("Decoded fields do not match frame.");
  property p_readback;
    @(posedge ref_clk_i) disable iff (rst_i) state == dac_cmd_pkg::ST_FETCH |=> sdo_shift[15:0] == $past(rd_data);
  endproperty
  a_readback: assert property (p_readback) else $error("Readback word not loaded.");
  property p_bipolar_code;
    @(posedge ref_clk_i) disable iff (rst_i) (level_hit && bipolar && dac_code == 12'h800) |=> level_o == -13'sd2048;
  endproperty
  a_bipolar_code: assert property (p_bipolar_code) else $error("Bipolar negative full scale wrong.");
  property p_unipolar_code;
    @(posedge ref_clk_i) disable iff (rst_i) (level_hit && !bipolar) |=> level_o == 13'($past(dac_code)) && level_valid_o;
  endproperty
  a_unipolar_code: assert property (p_unipolar_code) else $error("Unipolar code not straight binary.");
endmodule
`default_nettype wire

// File: test/host_link_model.sv
// Host side of the serial link: frame strobe, serial clock, data and readback.
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  output logic serial_clk_o,
  output logic frame_n_o,
  output logic sdata_o,
  input wire logic sdo_i
);
  initial begin
    serial_clk_o = 1'b0;
    frame_n_o = 1'b1;
    sdata_o = 1'b0;
  end
  // Shifts n bits from the top of bits, driving the second bit as 0, and collects the readback bits.
  task automatic send(input logic [31:0] bits, input int n, output logic [23:0] rb);
    rb = 24'h000000;
    frame_n_o = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      if (i < 24) begin
        rb[23 - i] = sdo_i;
      end
      serial_clk_o = 1'b1;
      #40;
      sdata_o = (i == 1) ? 1'b0 : bits[31 - i];
      #40;
      serial_clk_o = 1'b0;
      #80;
    end
    frame_n_o = 1'b1;
    sdata_o = ~sdata_o;
  endtask
endmodule
`default_nettype wire

// File: test/test_quad_dac_serial_command_decoder.sv
// Self-checking bench for the serial command decoder.
`timescale 1ns/100ps
`default_nettype none
module test_quad_dac_serial_command_decoder;
  typedef struct packed {
    logic [23:0] word;
    logic lv;
    logic [1:0] ch;
    logic [12:0] lvl;
    logic rbc;
    logic [23:0] rb;
  } row_s;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, frame_n, sdata, sdo, cmd_valid, level_valid;
  dac_cmd_pkg::cmd_s cmd;
  logic [1:0] level_ch;
  logic signed [12:0] level;
  logic [23:0] rb;
  int mismatches = 0;
  int samples_checked = 0;
  row_s rows [19] = '{
    {24'h080000, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h00fff0, 1'b1, 2'h0, 13'h0fff, 1'b0, 24'h000000},
    {24'h090003, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h017ff0, 1'b1, 2'h1, 13'h07ff, 1'b0, 24'h000000},
    {24'h018000, 1'b1, 2'h1, 13'h1800, 1'b0, 24'h000000},
    {24'h010000, 1'b1, 2'h1, 13'h0000, 1'b0, 24'h000000},
    {24'h121234, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h1b00a5, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h041230, 1'b1, 2'h0, 13'h0123, 1'b0, 24'h000000},
    {24'h201234, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h920000, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h9b0000, 1'b0, 2'h0, 13'h0000, 1'b1, 24'h921234},
    {24'h890000, 1'b0, 2'h0, 13'h0000, 1'b1, 24'h9b00a5},
    {24'h800000, 1'b0, 2'h0, 13'h0000, 1'b1, 24'h890003},
    {24'h800000, 1'b0, 2'h0, 13'h0000, 1'b1, 24'h801230},
    {24'h0f0005, 1'b0, 2'h0, 13'h0000, 1'b1, 24'h801230},
    {24'h8b0000, 1'b0, 2'h0, 13'h0000, 1'b0, 24'h000000},
    {24'h0a0005, 1'b0, 2'h0, 13'h0000, 1'b1, 24'h8b0000},
    {24'h02fff0, 1'b1, 2'h2, 13'h1fff, 1'b0, 24'h000000}
  };
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  host_link_model u_host (
    .serial_clk_o(sclk),
    .frame_n_o(frame_n),
    .sdata_o(sdata),
    .sdo_i(sdo)
  );
  quad_dac_serial_command_decoder u_dut (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .serial_clk_i(sclk),
    .frame_n_i(frame_n),
    .serial_data_in_i(sdata),
    .serial_data_out_o(sdo),
    .cmd_o(cmd),
    .cmd_valid_o(cmd_valid),
    .level_ch_o(level_ch),
    .level_o(level),
    .level_valid_o(level_valid)
  );
  task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_level(input string what, input logic signed [12:0] exp, input logic signed [12:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_cmd(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge ref_clk_i);
      #1;
      seen = (cmd_valid === 1'b1);
    end
  endtask
  task automatic do_row(input logic [31:0] bits, input int n, input row_s r);
    logic seen;
    u_host.send(bits, n, rb);
    if (r.rbc) begin
      check_word("readback", r.rb, rb);
    end
    wait_cmd(20, seen);
    if (!seen) begin
      mismatches++;
      wrap_up();
    end else begin
      check_word("cmd", r.word, cmd);
      check_flag("level_valid", r.lv, level_valid);
      if (r.lv) begin
        check_word("level_ch", {22'h000000, r.ch}, {22'h000000, level_ch});
        check_level("level", r.lvl, level);
      end
    end
  endtask
  initial begin
    logic seen;
    repeat (12) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    foreach (rows[i]) begin
      do_row({rows[i].word, 8'h00}, 24, rows[i]);
    end
    u_host.send(32'h00fff000, 23, rb);
    wait_cmd(30, seen);
    check_flag("partial frame pulse", 1'b0, seen);
    do_row(32'h01012080, 25, {24'h010120, 1'b1, 2'h1, 13'h0012, 1'b0, 24'h000000});
    @(posedge ref_clk_i);
    #1;
    rst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    check_word("cmd after reset", 24'h000000, cmd);
    check_level("level after reset", 13'h0000, level);
    check_flag("sdo after reset", 1'b0, sdo);
    repeat (3) @(posedge ref_clk_i);
    #1;
    do_row(32'h01800000, 24, {24'h018000, 1'b1, 2'h1, 13'h0800, 1'b0, 24'h000000});
    wrap_up();
  end
endmodule
`default_nettype wire
